// *** design/asrc_ctrl.sv ***
// Purpose: Host controller driving a 128K x 8 asynchronous SRAM
// Assumes: Pin inputs synchronous to i_clk; one request at a time
// Notes:   Every phase is at least one 50 ns cycle, above all minimums
`default_nettype none
// Behaviour
// - Write only while select and strobe low
// - Address stable long enough before write end
// - Select low long enough before write end
// - Write data set up before write end
// - Strobe pulse covers release plus set-up
// - Host never drives while memory drives
// - Address valid by select fall
module asrc_ctrl
  import asrc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_req_valid,
  input  wire asrc_req_type      i_req,
  output logic                   o_req_ready,
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rd_data,
  output asrc_pins_type          o_pins,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_dq_oe_b
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_RD_END, ST_WR_SET, ST_WR_PULSE, ST_WR_REC
  } asrc_state_type;

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta;
  logic rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta <= 1'b0;
      rst_b    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_b    <= rst_meta;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  asrc_state_type    state;
  asrc_state_type    next_state;
  asrc_pins_type     pins;
  asrc_pins_type     next_pins;
  logic [DATA_W-1:0] dq;
  logic [DATA_W-1:0] next_dq;
  logic              dq_oe_b;
  logic              next_dq_oe_b;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;
  logic              rd_valid;
  logic              next_rd_valid;
  logic              t_load;
  logic [CNT_W-1:0]  t_count;
  logic              t_done;

  asrc_timer u_timer (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_load  (t_load),
    .i_count (t_count),
    .o_done  (t_done)
  );

  localparam asrc_pins_type PINS_IDLE = '{cs_b: 1'b1, oe_b: 1'b1,
                                          we_b: 1'b1, addr: '0};

  always_comb
  begin
    next_state    = state;
    next_pins     = pins;
    next_dq       = dq;
    next_dq_oe_b  = dq_oe_b;
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    t_load        = 1'b0;
    t_count       = 4'h0;
    unique case (state)
      ST_IDLE:
      begin
        if (i_req_valid && t_done)
        begin
          t_load         = 1'b1;
          // Address and select move together
          next_pins.addr = i_req.addr;
          next_pins.cs_b = 1'b0;
          if (i_req.write)
          begin
            // Select before strobe, output enable held off
            next_pins.oe_b = 1'b1;
            next_dq        = i_req.wdata;
            next_dq_oe_b   = 1'b0;
            next_state     = ST_WR_SET;
            t_count        = 4'h1;
          end
          else
          begin
            next_pins.oe_b = 1'b0;
            next_pins.we_b = 1'b1;
            t_count        = CNT_W'(RD_CYC);
            next_state     = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (t_done)
        begin
          // Sampled after the whole access time has passed
          next_rd_data   = i_dq;
          next_rd_valid  = 1'b1;
          next_pins      = PINS_IDLE;
          next_pins.addr = pins.addr;
          t_load         = 1'b1;
          t_count        = CNT_W'(HZ_CYC);
          next_state     = ST_RD_END;
        end
      end
      ST_RD_END:
      begin
        // Memory outputs float before anything else may drive
        if (t_done)
          next_state = ST_IDLE;
      end
      ST_WR_SET:
      begin
        if (t_done)
        begin
          next_pins.we_b = 1'b0;
          t_load         = 1'b1;
          t_count        = CNT_W'(WP_CYC);
          next_state     = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE:
      begin
        if (t_done)
        begin
          // Strobe, select and address held through the pulse
          next_pins.we_b = 1'b1;
          next_pins.cs_b = 1'b1;
          t_load         = 1'b1;
          t_count        = CNT_W'(WC_CYC);
          next_state     = ST_WR_REC;
        end
      end
      ST_WR_REC:
      begin
        // Data hold is zero, so release right after the strobe
        next_dq_oe_b = 1'b1;
        if (t_done)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= ST_IDLE;
      pins     <= PINS_IDLE;
      dq       <= 8'h00;
      dq_oe_b  <= 1'b1;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      pins     <= next_pins;
      dq       <= next_dq;
      dq_oe_b  <= next_dq_oe_b;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // Low in reset so that no request is taken and then lost
  assign o_req_ready = (state == ST_IDLE) && t_done && rst_b;
  assign o_rd_valid  = rd_valid;
  assign o_rd_data   = rd_data;
  assign o_pins      = pins;
  assign o_dq        = dq;
  assign o_dq_oe_b   = dq_oe_b;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_strobe_fall;
    $fell(pins.we_b);
  endsequence

  sequence s_strobe_low_long;
    (!pins.we_b && !pins.cs_b)[*1] ##1 !pins.we_b;
  endsequence

  a_no_bus_fight: assert property (@(posedge i_clk) disable iff (!rst_b)
    !(!dq_oe_b && !pins.oe_b && !pins.cs_b))
    else $error("host drives while memory output enabled");

  a_write_needs_select: assert property (@(posedge i_clk)
    disable iff (!rst_b) !pins.we_b |-> !pins.cs_b && pins.oe_b)
    else $error("strobe low without select");

  a_strobe_width: assert property (@(posedge i_clk) disable iff (!rst_b)
    s_strobe_fall |-> s_strobe_low_long)
    else $error("strobe pulse too short");

  a_data_before_end: assert property (@(posedge i_clk)
    disable iff (!rst_b) $rose(pins.we_b) |->
    !$past(dq_oe_b) && $stable(dq))
    else $error("write data not set up before end");

  a_addr_hold_wr: assert property (@(posedge i_clk)
    disable iff (!rst_b) !pins.we_b |-> $stable(pins.addr))
    else $error("address moved during write pulse");

  a_select_before: assert property (@(posedge i_clk)
    disable iff (!rst_b) s_strobe_fall |-> !$past(pins.cs_b))
    else $error("select not low before strobe");

  a_read_latency: assert property (@(posedge i_clk) disable iff (!rst_b)
    $fell(pins.oe_b) |-> ##[1:3] rd_valid)
    else $error("read result late");

  a_write_spacing: assert property (@(posedge i_clk)
    disable iff (!rst_b) $rose(pins.we_b) |-> pins.we_b[*2])
    else $error("writes too close together");

  a_read_oe_off: assert property (@(posedge i_clk) disable iff (!rst_b)
    rd_valid |-> pins.oe_b && pins.cs_b ##2 state == ST_IDLE)
    else $error("memory output not released after read");
endmodule
`default_nettype wire

// *** design/asrc_pkg.sv ***
// Purpose: Constants and types for the async SRAM host controller
// Assumes: 20 MHz clock, 50 ns period
// Notes:   Times in ns; cycle counts derived from the clock period
`default_nettype none
package asrc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W        = 17;
  localparam int DATA_W        = 8;
  localparam int MEM_WORDS     = 131072;
  // Slow grade figures; the controller honours the worse of both grades
  localparam int T_ACCESS_NS   = 20;
  localparam int T_OE_NS       = 8;
  localparam int T_HZ_NS       = 8;
  localparam int T_WP_NS       = 15;
  localparam int T_CW_NS       = 15;
  localparam int T_DW_NS       = 9;
  localparam int T_WHZ_NS      = 8;
  localparam int T_WC_NS       = 20;
  // Least times round up to whole cycles, never below one
  function automatic int min_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_CYC  = min_cyc(T_ACCESS_NS);
  localparam int WP_CYC  = min_cyc(T_WHZ_NS + T_DW_NS);
  localparam int HZ_CYC  = min_cyc(T_HZ_NS);
  localparam int WC_CYC  = min_cyc(T_WC_NS);
  localparam int CNT_W   = 4;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_type;

  typedef struct packed {
    logic              cs_b;
    logic              oe_b;
    logic              we_b;
    logic [ADDR_W-1:0] addr;
  } asrc_pins_type;
endpackage
`default_nettype wire

// *** design/asrc_timer.sv ***
// Purpose: Down counter that times each phase of a memory cycle
// Assumes: Loaded with a non-zero count
// Notes:   o_done is high while the count is zero
`default_nettype none
module asrc_timer
  import asrc_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (i_load)
      next_count = i_count;
    else if (count != 4'h0)
      next_count = count - 4'h1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      count <= 4'h0;
    else
      count <= next_count;
  end

  assign o_done = (count == 4'h0);
endmodule
`default_nettype wire

// *** bench/asrc_sram_model.sv ***
// Purpose: Behavioural 128K x 8 async SRAM on the controller pins
// Assumes: Host data and enable given; bus resolved here
// Notes:   Undriven bus shows the inverse of its last driven value
`default_nettype none
module asrc_sram_model
  import asrc_pkg::*;
(
  input  wire asrc_pins_type     i_pins,
  input  wire logic [DATA_W-1:0] i_host_dq,
  input  wire logic              i_host_oe_b,
  input  var  int                i_acc_ns,
  output logic [DATA_W-1:0]      o_bus,
  output logic                   o_clash
);
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [DATA_W-1:0] last = '0;
  logic              drive;
  logic              drive_d = 1'b0;
  logic              wr_on;
  // -----------------------------------------
  // Output drive, slow to start, quick to stop
  // -----------------------------------------
  assign drive = !i_pins.cs_b && !i_pins.oe_b && i_pins.we_b;
  always @(drive)
    drive_d <= #(drive ? i_acc_ns : 1) drive;
  always @*
    if (!i_host_oe_b)
      last = i_host_dq;
    else if (drive_d)
      last = mem[i_pins.addr];
  assign o_bus   = !i_host_oe_b ? i_host_dq : drive_d ? mem[i_pins.addr] : ~last;
  assign o_clash = !i_host_oe_b && drive_d;
  // -----------------------------------------
  // Write lands when the select/strobe overlap ends
  // -----------------------------------------
  assign wr_on = !i_pins.cs_b && !i_pins.we_b;
  always @(negedge wr_on)
    mem[i_pins.addr] = o_bus;
endmodule
`default_nettype wire

// *** bench/tb_asrc_ctrl.sv ***
// Purpose: Self-checking bench for the async SRAM host controller
// Assumes: Pin walks as the controller sequences them
// Notes:   Snapshots taken at falling edges of cycles 1 to 7
`default_nettype none
module tb_asrc_ctrl
  import asrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              i_clk = 0;
  logic              i_rst_b = 0;
  logic              i_req_valid = 0;
  asrc_req_type      i_req = '0;
  logic              o_req_ready, o_rd_valid, o_dq_oe_b, clash;
  logic [DATA_W-1:0] o_rd_data, o_dq, bus;
  asrc_pins_type     o_pins;
  int                acc = 20;
  int                n_mismatch = 0;
  int                checks = 0;
  logic [3:0]        snap [1:7];
  logic              sv [1:7];
  logic [DATA_W-1:0] sd [1:7];
  logic [ADDR_W-1:0] sa [1:7];
  localparam logic [3:0] WEXP [1:6] = '{4'h6, 4'h6, 4'h4, 4'h4, 4'he, 4'hf};
  localparam logic [3:0] REXP [1:4] = '{4'h3, 4'h3, 4'hf, 4'hf};
  always #25 i_clk = ~i_clk;
  asrc_ctrl dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_pins(o_pins), .i_dq(bus), .o_dq(o_dq),
    .o_dq_oe_b(o_dq_oe_b));
  asrc_sram_model mem (.i_pins(o_pins), .i_host_dq(o_dq),
    .i_host_oe_b(o_dq_oe_b), .i_acc_ns(acc), .o_bus(bus), .o_clash(clash));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge i_clk)
    if (clash === 1'b1)
      check(clash, 0);
  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  task automatic t_reset();
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check({o_pins.cs_b, o_pins.oe_b, o_pins.we_b, o_dq_oe_b}, 4'hf);
    check(o_req_ready, 0);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(negedge i_clk);
    check(o_req_ready, 0);
    repeat (3) @(negedge i_clk);
    check(o_req_ready, 1);
  endtask
  task automatic run(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req <= '{w, a, d};
    @(negedge i_clk);
    while (o_req_ready !== 1'b1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    check(n < 20, 1);
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    for (int c = 1; c < 8; c++)
    begin
      @(negedge i_clk);
      snap[c] = {o_pins.cs_b, o_pins.oe_b, o_pins.we_b, o_dq_oe_b};
      sv[c] = o_rd_valid;
      sd[c] = o_dq;
      sa[c] = o_pins.addr;
    end
  endtask
  task automatic t_write(input logic [16:0] a, input logic [7:0] d);
    run(1'b1, a, d);
    for (int c = 1; c < 7; c++)
      check(snap[c], WEXP[c]);
    check({sa[1], sd[1]}, {a, d});
    check({sa[4], sd[4]}, {a, d});
    check(o_req_ready, 1);
  endtask
  task automatic t_read(input logic [16:0] a, input logic [7:0] d);
    run(1'b0, a, 8'h00);
    for (int c = 1; c < 5; c++)
      check({snap[c], sv[c]}, {REXP[c], c == 3});
    check({sa[1], o_rd_data}, {a, d});
  endtask
  task automatic t_abort();
    run(1'b1, 17'h1ffff, 8'h77);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req <= '{1'b1, 17'h00001, 8'h99};
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b0;
    i_req_valid <= 1'b0;
    @(negedge i_clk);
    check({o_pins.cs_b, o_pins.oe_b, o_pins.we_b, o_dq_oe_b}, 4'hf);
    t_reset();
  endtask
  initial
  begin
    t_reset();
    t_write(17'h00000, 8'h5a);
    t_write(17'h1ffff, 8'ha5);
    t_write(17'h0abcd, 8'h3c);
    t_read(17'h1ffff, 8'ha5);
    t_read(17'h00000, 8'h5a);
    acc = 3;
    t_read(17'h0abcd, 8'h3c);
    acc = 20;
    t_write(17'h00000, 8'hc3);
    t_read(17'h00000, 8'hc3);
    t_abort();
    t_read(17'h0abcd, 8'h3c);
    conclude();
  end
  initial
  begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
